// ==== src/wrc_counter.v ====
// Purpose: wrapping real-time counter with 16-bit prescaler, wrap flag, mask and direct wake
// Assumes: oscillator ticks arrive as pins from outside the sys_clk domain
// Notes: oscillator inputs are sampled; each rising edge of the selected input is one prescaler step while enabled and not halted
`timescale 1ns/1ps
`include "wrc_map.vh"

module wrc_counter #(
  parameter PRE_W = 16,
  parameter CNT_W = 32
) (
  input wire sysClk,
  input wire rst_n,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdata,
  input wire rcOscPin,
  input wire xtalOscPin,
  input wire staticSleep,
  input wire deepStopSleep,
  input wire debugHalt,
  input wire debugKeepRun,
  output wire irqReq,
  output wire wakeReq
);

  // ==========================================================
  // Register port decode
  function isAddr;
    input [7:0] a;
    input [7:0] off;
    begin
      isAddr = (a == off);
    end
  endfunction

  reg ctlEn_r;
  reg ctlWaken_r;
  reg ctlXtal_r;
  reg ctlClken_r;
  reg [3:0] ctlPsel_r;
  reg [CNT_W-1:0] limit_r;
  reg [CNT_W-1:0] count_r;
  reg [PRE_W-1:0] pre_r;
  reg mask_r;
  reg wrapFlag_r;
  reg [2:0] busyCnt_r;
  reg wakeLatch_r;
  reg [2:0] rcSync_r;
  reg [2:0] xtSync_r;

  wire busy = (busyCnt_r != 3'h0);
  wire wrCtl = regWr && isAddr(regAddr, `WRC_OFF_CONTROL) && !busy;
  wire wrVal = regWr && isAddr(regAddr, `WRC_OFF_VALUE) && !busy;
  wire wrLim = regWr && isAddr(regAddr, `WRC_OFF_LIMIT) && !busy;

  // ==========================================================
  // Oscillator input sampling: an edge counts once stages 2 and 3 agree
  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      rcSync_r <= 3'h0;
      xtSync_r <= 3'h0;
    end else begin
      rcSync_r <= {rcSync_r[1:0], rcOscPin};
      xtSync_r <= {xtSync_r[1:0], xtalOscPin};
    end
  end

  reg rcLvl_r;
  reg xtLvl_r;
  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      rcLvl_r <= 1'b0;
      xtLvl_r <= 1'b0;
    end else begin
      if (rcSync_r[2] == rcSync_r[1])
        rcLvl_r <= rcSync_r[2];
      if (xtSync_r[2] == xtSync_r[1])
        xtLvl_r <= xtSync_r[2];
    end
  end

  wire rcRise = (rcSync_r[2] == rcSync_r[1]) && rcSync_r[2] && !rcLvl_r;
  wire xtRise = (xtSync_r[2] == xtSync_r[1]) && xtSync_r[2] && !xtLvl_r;
  wire srcTick = ctlXtal_r ? xtRise : rcRise;

  // Halted in static sleep, or debug without keep-running
  wire frozen = staticSleep || (debugHalt && !debugKeepRun);
  wire preStep = ctlEn_r && srcTick && !frozen;

  // ==========================================================
  // Prescaler and count clock tap
  wire [PRE_W-1:0] preNxt = pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
  // Tap bit rising means a count clock edge: f = fin / 2^(psel+1)
  wire tapRise = preStep && !pre_r[ctlPsel_r] && preNxt[ctlPsel_r];

  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= {PRE_W{1'b0}};
    end else if (wrCtl && regWdata[`WRC_CTL_PRESCALER_CLEAR]) begin
      pre_r <= {PRE_W{1'b0}};
    end else if (preStep) begin
      pre_r <= preNxt;
    end
  end

  // ==========================================================
  // Counter, wrap and flag
  wire atTop = (count_r == limit_r);
  wire wrapEvt = tapRise && atTop;

  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= `WRC_RST_VALUE;
    end else if (wrVal) begin
      count_r <= regWdata;
    end else if (tapRise) begin
      // Period from zero back to zero is limit plus one ticks
      count_r <= atTop ? {CNT_W{1'b0}} : count_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  wire flagClr = regWr && isAddr(regAddr, `WRC_OFF_IFLAG_CLR) && regWdata[`WRC_WRAP_BIT];

  // A wrap in the clearing cycle wins so no event is lost
  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      wrapFlag_r <= 1'b0;
    end else if (wrapEvt) begin
      wrapFlag_r <= 1'b1;
    end else if (flagClr) begin
      wrapFlag_r <= 1'b0;
    end
  end

  // ==========================================================
  // Mask
  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 1'b0;
    end else if (regWr && isAddr(regAddr, `WRC_OFF_IEN_SET) && regWdata[`WRC_WRAP_BIT]) begin
      mask_r <= 1'b1;
    end else if (regWr && isAddr(regAddr, `WRC_OFF_IEN_CLR) && regWdata[`WRC_WRAP_BIT]) begin
      mask_r <= 1'b0;
    end
  end

  assign irqReq = wrapFlag_r && mask_r && !deepStopSleep && !staticSleep;

  // ==========================================================
  // Direct wake: held until software drops wake enable
  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      wakeLatch_r <= 1'b0;
    end else if (!ctlWaken_r) begin
      wakeLatch_r <= 1'b0;
    end else if (wrapEvt || wrapFlag_r) begin
      wakeLatch_r <= 1'b1;
    end
  end

  assign wakeReq = wakeLatch_r && !staticSleep;

  // ==========================================================
  // Control, limit and busy
  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      ctlEn_r <= 1'b0;
      ctlWaken_r <= 1'b0;
      ctlXtal_r <= 1'b0;
      ctlClken_r <= 1'b1;
      ctlPsel_r <= 4'h0;
      limit_r <= `WRC_RST_LIMIT;
      busyCnt_r <= 3'h0;
    end else begin
      if (wrCtl) begin
        ctlEn_r <= regWdata[`WRC_CTL_EN];
        ctlWaken_r <= regWdata[`WRC_CTL_WAKE_ENABLE];
        ctlXtal_r <= regWdata[`WRC_CTL_XTAL];
        ctlClken_r <= regWdata[`WRC_CTL_CLKEN];
        ctlPsel_r <= regWdata[`WRC_CTL_PSEL_HI:`WRC_CTL_PSEL_LO];
      end
      if (wrLim)
        limit_r <= regWdata;
      // Models the domain crossing delay of the original design
      if (wrCtl || wrVal || wrLim)
        busyCnt_r <= `WRC_XFER_CYCLES;
      else if (busy)
        busyCnt_r <= busyCnt_r - 3'h1;
    end
  end

  // ==========================================================
  // Read data, valid the cycle after the strobe
  always @(posedge sysClk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      case (regAddr)
        `WRC_OFF_CONTROL:
          regRdata <= {15'h0000, ctlClken_r, 4'h0, ctlPsel_r, 3'h0, busy, ctlXtal_r, ctlWaken_r, 1'b0, ctlEn_r};
        `WRC_OFF_VALUE:
          regRdata <= count_r;
        `WRC_OFF_LIMIT:
          regRdata <= limit_r;
        `WRC_OFF_IMASK:
          regRdata <= {31'h0000_0000, mask_r};
        `WRC_OFF_IFLAG:
          regRdata <= {31'h0000_0000, wrapFlag_r};
        default:
          regRdata <= 32'h0000_0000;
      endcase
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

endmodule // wrc_counter

// ==== src/wrc_map.vh ====
// Purpose: register map, field positions, reset values and timing counts of the wrapping real-time counter
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes: definitions only
`ifndef WRC_MAP_VH
`define WRC_MAP_VH

// ==========================================================
// Register offsets
`define WRC_OFF_CONTROL 8'h00
`define WRC_OFF_VALUE 8'h04
`define WRC_OFF_LIMIT 8'h08
`define WRC_OFF_IEN_SET 8'h10
`define WRC_OFF_IEN_CLR 8'h14
`define WRC_OFF_IMASK 8'h18
`define WRC_OFF_IFLAG 8'h1c
`define WRC_OFF_IFLAG_CLR 8'h20

// ==========================================================
// Control fields
`define WRC_CTL_EN 0
`define WRC_CTL_PRESCALER_CLEAR 1
`define WRC_CTL_WAKE_ENABLE 2
`define WRC_CTL_XTAL 3
`define WRC_CTL_BUSY 4
`define WRC_CTL_PSEL_LO 8
`define WRC_CTL_PSEL_HI 11
`define WRC_CTL_CLKEN 16
`define WRC_WRAP_BIT 0

// ==========================================================
// Reset values
`define WRC_RST_CONTROL 32'h0001_0000
`define WRC_RST_VALUE 32'h0000_0000
`define WRC_RST_LIMIT 32'hffff_ffff

// ==========================================================
// Timing: cycles for a register write to reach the counter side
`define WRC_XFER_CYCLES 3'h3

`endif

// ==== test/wrc_counter_asserts.sv ====
// Purpose: port checks of wrc_counter
// Assumes: one clock domain, async active-low reset
// Notes: flags are seen only through register reads
`timescale 1ns/1ps
module wrc_counter_asserts (
  input wire sysClk,
  input wire rst_n,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdata,
  input wire staticSleep,
  input wire deepStopSleep,
  input wire irqReq,
  input wire wakeReq
);
  // ========================================
  // Checks
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (!rst_n);
  wire ctlWr = regWr && (regAddr == 8'h00 || regAddr == 8'h04 || regAddr == 8'h08);
  sequence s_rd(a); regRd && regAddr == a; endsequence
  sequence s_one(a); regWr && regAddr == a && regWdata[0]; endsequence
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside slot");
  a_clear_reads_zero: assert property (s_rd(8'h00) |=> !regRdata[1])
    else $error("prescaler clear read one");
  a_mask_set_seen: assert property (s_one(8'h10) ##1 !regWr ##1 s_rd(8'h18) |=> regRdata[0])
    else $error("mask not set");
  a_mask_clr_seen: assert property (s_one(8'h14) ##1 !regWr ##1 s_rd(8'h18) |=> !regRdata[0])
    else $error("mask not cleared");
  a_irq_needs_mask: assert property (s_one(8'h14) |=> !irqReq)
    else $error("irq with mask off");
  a_irq_deep_off: assert property (deepStopSleep |-> !irqReq)
    else $error("irq in deep stop");
  a_static_quiet: assert property (staticSleep |-> !irqReq && !wakeReq)
    else $error("request in static");
  // The stored wake enable lags the write by one cycle, so the latch drops two cycles after it
  a_wake_holds: assert property (wakeReq && !(regWr && regAddr == 8'h00) && !$past(regWr && regAddr == 8'h00)
    |=> wakeReq || staticSleep)
    else $error("wake dropped");
  a_busy_after_wr: assert property ((!ctlWr)[*4] ##1 ctlWr ##1 !regWr ##1 s_rd(8'h00) |=> regRdata[4])
    else $error("busy not shown");
endmodule // wrc_counter_asserts
bind wrc_counter wrc_counter_asserts u_chk (.sysClk(sysClk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .staticSleep(staticSleep), .deepStopSleep(deepStopSleep),
  .irqReq(irqReq), .wakeReq(wakeReq));

// ==== test/tb_wrapping_real_time_counter.sv ====
// Purpose: self-checking bench of wrc_counter
// Assumes: bench toggles the oscillator pins slowly
// Notes: each pin level held 4 clocks so the sampler never misses it
`timescale 1ns/1ps
module tb_wrapping_real_time_counter;
  // ========================================
  // Signals and clock
  logic sysClk = 0, rst_n = 0, regWr = 0, regRd = 0, rcOscPin = 0, xtalOscPin = 0;
  logic staticSleep = 0, deepStopSleep = 0, debugHalt = 0, debugKeepRun = 0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  wire [31:0] regRdata;
  wire irqReq, wakeReq;
  int failCount = 0, compares = 0, cycles = 0;
  initial begin
    forever #4 sysClk = ~sysClk;
  end
  wrc_counter u_wrc_counter (.sysClk(sysClk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .rcOscPin(rcOscPin), .xtalOscPin(xtalOscPin), .staticSleep(staticSleep),
    .deepStopSleep(deepStopSleep), .debugHalt(debugHalt), .debugKeepRun(debugKeepRun), .irqReq(irqReq),
    .wakeReq(wakeReq));
  // ========================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // Gap n keeps the strobe from being dropped and raised in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sysClk);
    regWr <= 1'b0;
    repeat (n) @(posedge sysClk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sysClk);
    regRd <= 1'b0;
    #1 chk("regRdata", regRdata, e);
    @(posedge sysClk);
  endtask
  task automatic osc(input bit xt, input int n);
    repeat (n) begin
      if (xt) xtalOscPin <= 1'b1;
      else rcOscPin <= 1'b1;
      repeat (4) @(posedge sysClk);
      xtalOscPin <= 1'b0;
      rcOscPin <= 1'b0;
      repeat (4) @(posedge sysClk);
    end
    repeat (6) @(posedge sysClk);
  endtask
  task automatic wrap_up;
    $display("compares %0d failCount %0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failCount++;
      wrap_up();
    end
  end
  // ========================================
  // Sequence
  initial begin
    repeat (5) @(posedge sysClk);
    rst_n <= 1'b1;
    @(posedge sysClk);
    rd(8'h00, 32'h0001_0000);
    rd(8'h08, 32'hffff_ffff);
    rd(8'h1c, 32'h0);
    rd(8'h0c, 32'h0);
    wr(8'h04, 32'h5, 1);
    wr(8'h04, 32'h9, 4);
    rd(8'h04, 32'h5);
    wr(8'h08, 32'h3, 1);
    rd(8'h00, 32'h0001_0010);
    rd(8'h00, 32'h0001_0000);
    wr(8'h04, 32'h0, 4);
    wr(8'h10, 32'h1, 1);
    rd(8'h18, 32'h1);
    wr(8'h14, 32'h0, 1);
    rd(8'h18, 32'h1);
    wr(8'h14, 32'h1, 1);
    rd(8'h18, 32'h0);
    wr(8'h10, 32'h1, 1);
    osc(0, 2);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'h0001_0001, 4);
    osc(0, 6);
    rd(8'h04, 32'h3);
    rd(8'h1c, 32'h0);
    osc(0, 1);
    rd(8'h04, 32'h0);
    rd(8'h1c, 32'h1);
    chk("irqReq", 32'(irqReq), 32'h1);
    deepStopSleep <= 1'b1;
    @(posedge sysClk);
    #1 chk("irqReq", 32'(irqReq), 32'h0);
    deepStopSleep <= 1'b0;
    wr(8'h20, 32'h0, 1);
    rd(8'h1c, 32'h1);
    wr(8'h20, 32'h1, 1);
    rd(8'h1c, 32'h0);
    // Clear plus tap 1: three steps give one tick whether or not the prescaler is cleared
    wr(8'h00, 32'h0001_0103, 4);
    osc(0, 3);
    rd(8'h04, 32'h1);
    debugHalt <= 1'b1;
    osc(0, 4);
    rd(8'h04, 32'h1);
    // Keep-running overrides the debug halt: four steps give one tap edge
    debugKeepRun <= 1'b1;
    osc(0, 4);
    rd(8'h04, 32'h2);
    debugHalt <= 1'b0;
    debugKeepRun <= 1'b0;
    wr(8'h00, 32'h0001_010b, 4);
    osc(0, 8);
    rd(8'h04, 32'h2);
    osc(1, 4);
    rd(8'h04, 32'h3);
    wr(8'h14, 32'h1, 1);
    wr(8'h00, 32'h0001_0105, 4);
    chk("wakeReq", 32'(wakeReq), 32'h0);
    osc(0, 8);
    chk("wakeReq", 32'(wakeReq), 32'h1);
    chk("irqReq", 32'(irqReq), 32'h0);
    staticSleep <= 1'b1;
    @(posedge sysClk);
    #1 chk("wakeReq", 32'(wakeReq), 32'h0);
    staticSleep <= 1'b0;
    wr(8'h20, 32'h1, 4);
    chk("wakeReq", 32'(wakeReq), 32'h1);
    wr(8'h00, 32'h0001_0101, 4);
    chk("wakeReq", 32'(wakeReq), 32'h0);
    wr(8'h00, 32'h0001_0000, 4);
    rd(8'h00, 32'h0001_0000);
    wrap_up();
  end
endmodule // tb_wrapping_real_time_counter
